//--- rtl/tsra_pkg.sv
// constants and register layout for the temperature sensor register access block
// Functional notes
// - invalid selector byte is not acknowledged and the stored selector stays unchanged.
// - selector bits 2:0 choose result, config, upper, lower, control, ident; others invalid.
// - read with preset selector is address byte then data from that register.
// - data bytes leave on the data line most significant bit first.
// - after each read byte master may acknowledge or not; not ends the read.
// - selector keeps last valid choice across transactions.
// - every register, selector included, returns to its reset value at power up.
// - on shutdown the running conversion finishes and updates the result first.
// - clearing power down resumes continuous conversion; first result after one conversion.
// - result bits 15:2 hold latest conversion; bits 1:0 read zero.
// - result invalid until first conversion completes, then valid flag goes high.
// - resolution 11 to 14 bits chosen by control register bits 6 and 5.
// - config bit 5 low enables alarm output; status bit follows the pin.
// - config bit 4 sets alarm polarity, 1 active high, 0 active low.
// - writing 1 to config bit 3 clears alarm; bit reads back 0.
// - config bit 2 while powered down starts one conversion; reads 0.
// - resolution code 00,01,10,11 selects 11,12,13,14 bit words.
// - end of conversion compares result with limits to raise or drop alarm.

package tsra_pkg;

  // ----------------------------------------------------------------
  // selector codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEL_RESULT   = 3'h0;
  localparam logic [2:0]  SEL_CONFIG   = 3'h1;
  localparam logic [2:0]  SEL_UPPER    = 3'h2;
  localparam logic [2:0]  SEL_LOWER    = 3'h3;
  localparam logic [2:0]  SEL_CTRL     = 3'h4;
  localparam logic [2:0]  SEL_IDENT    = 3'h7;
  localparam logic [2:0]  SEL_RST      = 3'h0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RESULT_RST   = 16'h7FFC;
  localparam logic [7:0]  CONFIG_RST   = 8'h40;
  localparam logic [15:0] UPPER_RST    = 16'h7FE0;
  localparam logic [15:0] LOWER_RST    = 16'h8000;
  localparam logic [1:0]  RES_RST      = 2'h0;

  // ----------------------------------------------------------------
  // configuration register fields
  // ----------------------------------------------------------------
  localparam int          CFG_PD       = 7;
  localparam int          CFG_ONE      = 6;
  localparam int          CFG_ALRT_DIS = 5;
  localparam int          CFG_POL      = 4;
  localparam int          CFG_CLR      = 3;
  localparam int          CFG_SHOT     = 2;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int          CTL_TO_DIS   = 7;
  localparam int          CTL_RES_HI   = 6;
  localparam int          CTL_RES_LO   = 5;

  // ----------------------------------------------------------------
  // result masks per resolution and limit compare window
  // ----------------------------------------------------------------
  localparam logic [1:0]  RES_11       = 2'h0;
  localparam logic [1:0]  RES_12       = 2'h1;
  localparam logic [1:0]  RES_13       = 2'h2;
  localparam logic [15:0] MASK_11      = 16'hFFE0;
  localparam logic [15:0] MASK_12      = 16'hFFF0;
  localparam logic [15:0] MASK_13      = 16'hFFF8;
  localparam logic [15:0] MASK_14      = 16'hFFFC;
  localparam logic [15:0] LIMIT_MASK   = 16'hFFE0;
  localparam int          CMP_LSB      = 5;

  // ----------------------------------------------------------------
  // link byte handling
  // ----------------------------------------------------------------
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [2:0]  IDX_ADDR     = 3'h0;
  localparam logic [2:0]  IDX_SEL      = 3'h1;
  localparam logic [2:0]  IDX_DATA0    = 3'h2;
  localparam logic [2:0]  IDX_DATA1    = 3'h3;
  localparam logic [2:0]  IDX_MAX      = 3'h4;

endpackage : tsra_pkg

//--- rtl/tsra_sync.sv
// two flip-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps

module tsra_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,   // destination clock
  input  wire logic             i_rstn,  // async reset, active low
  input  wire logic [WIDTH-1:0] i_async, // level from another domain
  output logic      [WIDTH-1:0] o_sync   // synchronised level
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : tsra_sync

//--- rtl/tsra_top.sv
// register access, conversion control and serial slave of the temperature sensor
`timescale 1ns/1ps

module tsra_top #(
  parameter logic [6:0]  DEV_ADDR    = 7'h48,   // slave address
  parameter logic [15:0] IDENT_VALUE = 16'h1234 // arbitrary identification value
) (
  input  wire logic        i_clk,          // system clock, 20 MHz
  input  wire logic        i_rstn,         // power-up reset, active low
  input  wire logic        i_scl,          // serial clock from the master
  input  wire logic        i_sda_i,        // serial data line level
  output logic             o_sda_o,        // serial data drive value, always low
  output logic             o_sda_oe,       // high while pulling data low
  input  wire logic        i_conv_done,    // converter finished, one-cycle pulse
  input  wire logic [13:0] i_conv_temp,    // left-justified conversion word
  output logic             o_conv_start,   // start one conversion, one-cycle pulse
  output logic [1:0]       o_conv_res,     // resolution code for the converter
  output logic             o_powered_down, // shutdown reached
  output logic             o_alert_o,      // alarm drive value, always low
  output logic             o_alert_oe      // high while pulling alarm pin low
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]  bus_s;
  logic        sda_p_q;
  logic        frame_q;
  logic        clr_q;
  logic        link_rstn;
  logic [7:0]  sh_q;
  logic [3:0]  bit_q;
  logic        mnack_q;
  logic        sel_q;
  logic        rw_q;
  logic [2:0]  idx_q;
  logic [7:0]  tx_q;
  logic        bsel_q;
  logic        ev_tgl_q;
  logic        ev_kind_q;
  logic        ev_idx_q;
  logic [7:0]  ev_byte_q;
  logic        ev_s;
  logic        ev_p_q;
  logic        ev_dly_q;
  logic [2:0]  ptr_q;
  logic [15:0] result_q;
  logic        cfg_pd_q;
  logic        cfg_one_q;
  logic        cfg_dis_q;
  logic        cfg_pol_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [7:0]  hold_q;
  logic        to_dis_q;
  logic [1:0]  res_q;
  logic        thi_q;
  logic        lower_limit_q;
  logic        dav_q;
  logic        alarm_q;
  logic        lvl_q;
  logic        busy_q;
  logic        shot_q;
  logic [15:0] rd_word_q;
  logic        rd_wide_q;

  localparam int CFG_PD   = tsra_pkg::CFG_PD;
  localparam int CFG_CLR  = tsra_pkg::CFG_CLR;
  localparam int CFG_SHOT = tsra_pkg::CFG_SHOT;
  localparam int CMP_LSB  = tsra_pkg::CMP_LSB;

  // ----------------------------------------------------------------
  // frame detection in the system domain
  // ----------------------------------------------------------------
  tsra_sync #(.WIDTH(2)) u_bus_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async ({i_scl, i_sda_i}),
    .o_sync  (bus_s)
  );

  wire scl_s     = bus_s[1];
  wire sda_s     = bus_s[0];
  wire start_det = scl_s & sda_p_q & ~sda_s;
  wire stop_det  = scl_s & ~sda_p_q & sda_s;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sda_p_q <= 1'b1;
      frame_q <= 1'b0;
      clr_q   <= 1'b0;
    end else begin
      sda_p_q <= sda_s;
      frame_q <= start_det | (frame_q & ~stop_det);
      clr_q   <= start_det | stop_det;
    end
  end

  // start and stop restart the link engine; scl is high, so release precedes its next edge
  assign link_rstn = i_rstn & ~clr_q;

  // ----------------------------------------------------------------
  // link domain: bit capture on the rising serial clock
  // ----------------------------------------------------------------
  always_ff @(posedge i_scl or negedge link_rstn) begin
    if (!link_rstn) begin
      sh_q    <= 8'h00;
      bit_q   <= 4'h0;
      mnack_q <= 1'b0;
    end else if (bit_q == tsra_pkg::BIT_ACK) begin
      bit_q   <= 4'h0;
      mnack_q <= rw_q & i_sda_i;
    end else begin
      sh_q    <= {sh_q[6:0], i_sda_i};
      bit_q   <= bit_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // link domain: byte decisions and drive on the falling serial clock
  // ----------------------------------------------------------------
  wire       ack_slot  = (bit_q == tsra_pkg::BIT_ACK);
  wire [2:0] sel_code  = sh_q[2:0];
  wire       code_ok   = (sel_code <= tsra_pkg::SEL_CTRL) || (sel_code == tsra_pkg::SEL_IDENT);
  wire       ptr_ok    = (sh_q[7:3] == 5'h00) && code_ok;
  wire       addr_hit  = (sh_q[7:1] == DEV_ADDR);
  wire       wr_phase  = sel_q & ~rw_q & (idx_q != tsra_pkg::IDX_ADDR);
  wire       ev_fire   = ack_slot & wr_phase & ((idx_q == tsra_pkg::IDX_SEL) ? ptr_ok : (idx_q < tsra_pkg::IDX_MAX));
  wire [7:0] first_byte = rd_wide_q ? rd_word_q[15:8] : rd_word_q[7:0];
  wire [7:0] next_byte  = (rd_wide_q & ~bsel_q) ? rd_word_q[15:8] : rd_word_q[7:0];
  wire       tx_bit     = tx_q[3'h7 - bit_q[2:0]];
  wire       rd_drive   = sel_q & rw_q & (idx_q != tsra_pkg::IDX_ADDR) & ~mnack_q;

  always_ff @(negedge i_scl or negedge link_rstn) begin
    if (!link_rstn) begin
      o_sda_oe <= 1'b0;
      sel_q    <= 1'b0;
      rw_q     <= 1'b0;
      idx_q    <= tsra_pkg::IDX_ADDR;
      tx_q     <= 8'h00;
      bsel_q   <= 1'b0;
    end else if (ack_slot) begin
      idx_q <= (idx_q == tsra_pkg::IDX_MAX) ? idx_q : idx_q + 3'h1;
      if (idx_q == tsra_pkg::IDX_ADDR) begin
        o_sda_oe <= addr_hit;
        sel_q    <= addr_hit;
        rw_q     <= sh_q[0];
        tx_q     <= first_byte;
        bsel_q   <= 1'b1;
      end else if (wr_phase) begin
        o_sda_oe <= (idx_q != tsra_pkg::IDX_SEL) | ptr_ok;
        sel_q    <= (idx_q != tsra_pkg::IDX_SEL) | ptr_ok;
      end else begin
        o_sda_oe <= 1'b0;
        tx_q     <= next_byte;
        bsel_q   <= ~bsel_q;
      end
    end else begin
      o_sda_oe <= rd_drive & ~tx_bit;
    end
  end

  // event words survive frame restarts so no spurious toggle reaches the system side
  always_ff @(negedge i_scl or negedge i_rstn) begin
    if (!i_rstn) begin
      ev_tgl_q  <= 1'b0;
      ev_kind_q <= 1'b0;
      ev_idx_q  <= 1'b0;
      ev_byte_q <= 8'h00;
    end else if (ev_fire) begin
      ev_tgl_q  <= ~ev_tgl_q;
      ev_kind_q <= (idx_q == tsra_pkg::IDX_SEL);
      ev_idx_q  <= (idx_q == tsra_pkg::IDX_DATA1);
      ev_byte_q <= sh_q;
    end
  end

  // ----------------------------------------------------------------
  // event crossing into the system domain
  // ----------------------------------------------------------------
  tsra_sync #(.WIDTH(1)) u_ev_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async (ev_tgl_q),
    .o_sync  (ev_s)
  );

  wire ev_new  = ev_s ^ ev_p_q;
  wire ev_ptr  = ev_new & ev_kind_q;
  wire ev_data = ev_new & ~ev_kind_q;
  wire wr_cfg  = ev_data & ~ev_idx_q & (ptr_q == tsra_pkg::SEL_CONFIG);
  wire wr_ctl  = ev_data & ~ev_idx_q & (ptr_q == tsra_pkg::SEL_CTRL);
  wire wr_up   = ev_data & ev_idx_q & (ptr_q == tsra_pkg::SEL_UPPER);
  wire wr_low  = ev_data & ev_idx_q & (ptr_q == tsra_pkg::SEL_LOWER);
  wire [15:0] wr_word = {hold_q, ev_byte_q} & tsra_pkg::LIMIT_MASK;

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  wire        start_d  = ~busy_q & ~o_conv_start & (~cfg_pd_q | shot_q);
  wire        done     = i_conv_done & busy_q;
  wire [15:0] res_mask = (res_q == tsra_pkg::RES_11) ? tsra_pkg::MASK_11 :
                         (res_q == tsra_pkg::RES_12) ? tsra_pkg::MASK_12 :
                         (res_q == tsra_pkg::RES_13) ? tsra_pkg::MASK_13 : tsra_pkg::MASK_14;
  wire [15:0] new_res  = {i_conv_temp, 2'b00} & res_mask;
  wire        over     = $signed(new_res[15:CMP_LSB]) > $signed(upper_q[15:CMP_LSB]);
  wire        under    = $signed(new_res[15:CMP_LSB]) < $signed(lower_q[15:CMP_LSB]);
  wire        clr_alrm = wr_cfg & ev_byte_q[CFG_CLR];
  wire        shot_set = wr_cfg & ev_byte_q[CFG_PD] & ev_byte_q[CFG_SHOT];
  // a conversion result that raises the alarm wins over a clear in the same cycle
  wire        alarm_d  = (done & over) ? 1'b1 : (done & under) ? 1'b0 : clr_alrm ? 1'b0 : alarm_q;
  wire        lvl_d    = (alarm_q & ~cfg_dis_q) ? cfg_pol_q : ~cfg_pol_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q         <= 1'b0;
      o_conv_start   <= 1'b0;
      shot_q         <= 1'b0;
      o_powered_down <= 1'b0;
      result_q       <= tsra_pkg::RESULT_RST;
      dav_q          <= 1'b0;
      thi_q          <= 1'b0;
      lower_limit_q         <= 1'b0;
      alarm_q        <= 1'b0;
    end else begin
      o_conv_start   <= start_d;
      busy_q         <= start_d | (busy_q & ~i_conv_done);
      shot_q         <= shot_set | (shot_q & ~(start_d & cfg_pd_q));
      o_powered_down <= cfg_pd_q & ~busy_q & ~start_d & ~shot_q;
      alarm_q        <= alarm_d;
      if (done) begin
        result_q     <= new_res;
        dav_q        <= 1'b1;
        thi_q        <= over;
        lower_limit_q       <= under;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ev_p_q    <= 1'b0;
      ev_dly_q  <= 1'b0;
      ptr_q     <= tsra_pkg::SEL_RST;
      cfg_pd_q  <= tsra_pkg::CONFIG_RST[tsra_pkg::CFG_PD];
      cfg_one_q <= tsra_pkg::CONFIG_RST[tsra_pkg::CFG_ONE];
      cfg_dis_q <= tsra_pkg::CONFIG_RST[tsra_pkg::CFG_ALRT_DIS];
      cfg_pol_q <= tsra_pkg::CONFIG_RST[tsra_pkg::CFG_POL];
      upper_q   <= tsra_pkg::UPPER_RST;
      lower_q   <= tsra_pkg::LOWER_RST;
      hold_q    <= 8'h00;
      to_dis_q  <= 1'b0;
      res_q     <= tsra_pkg::RES_RST;
    end else begin
      ev_p_q   <= ev_s;
      ev_dly_q <= ev_new;
      if (ev_ptr) begin
        ptr_q <= ev_byte_q[2:0];
      end
      if (ev_data & ~ev_idx_q) begin
        hold_q <= ev_byte_q;
      end
      if (wr_cfg) begin
        cfg_pd_q  <= ev_byte_q[tsra_pkg::CFG_PD];
        cfg_one_q <= ev_byte_q[tsra_pkg::CFG_ONE];
        cfg_dis_q <= ev_byte_q[tsra_pkg::CFG_ALRT_DIS];
        cfg_pol_q <= ev_byte_q[tsra_pkg::CFG_POL];
      end
      if (wr_ctl) begin
        to_dis_q <= ev_byte_q[tsra_pkg::CTL_TO_DIS];
        res_q    <= ev_byte_q[tsra_pkg::CTL_RES_HI:tsra_pkg::CTL_RES_LO];
      end
      if (wr_up) begin
        upper_q <= wr_word;
      end
      if (wr_low) begin
        lower_q <= wr_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // read word, frozen during a frame except after a write event
  // ----------------------------------------------------------------
  wire [7:0]  cfg_rd  = {cfg_pd_q, cfg_one_q, cfg_dis_q, cfg_pol_q, 4'h0};
  wire [7:0]  ctl_rd  = {to_dis_q, res_q, 1'b0, lvl_q, thi_q, lower_limit_q, dav_q};
  wire [15:0] rd_mux  = (ptr_q == tsra_pkg::SEL_RESULT) ? result_q :
                        (ptr_q == tsra_pkg::SEL_CONFIG) ? {8'h00, cfg_rd} :
                        (ptr_q == tsra_pkg::SEL_UPPER)  ? upper_q :
                        (ptr_q == tsra_pkg::SEL_LOWER)  ? lower_q :
                        (ptr_q == tsra_pkg::SEL_CTRL)   ? {8'h00, ctl_rd} : IDENT_VALUE;
  wire        rd_wide = (ptr_q != tsra_pkg::SEL_CONFIG) && (ptr_q != tsra_pkg::SEL_CTRL);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_word_q <= tsra_pkg::RESULT_RST;
      rd_wide_q <= 1'b1;
    end else if (~frame_q | ev_dly_q) begin
      rd_word_q <= rd_mux;
      rd_wide_q <= rd_wide;
    end
  end

  // ----------------------------------------------------------------
  // alarm pin and fixed drive values
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_q      <= 1'b1;
      o_alert_oe <= 1'b0;
      o_alert_o  <= 1'b0;
      o_sda_o    <= 1'b0;
      o_conv_res <= tsra_pkg::RES_RST;
    end else begin
      lvl_q      <= lvl_d;
      o_alert_oe <= ~lvl_d;
      o_alert_o  <= 1'b0;
      o_sda_o    <= 1'b0;
      o_conv_res <= res_q;
    end
  end

endmodule : tsra_top

//--- testbench/tsra_chk.sv
// port assertions of the temperature sensor register access block
`timescale 1ns/1ps

module tsra_chk (
  input wire logic        i_clk,          // system clock
  input wire logic        i_rstn,         // reset, active low
  input wire logic        i_scl,          // serial clock
  input wire logic        i_sda_i,        // data line level
  input wire logic        o_sda_o,        // data drive value
  input wire logic        o_sda_oe,       // data pull enable
  input wire logic        i_conv_done,    // conversion end
  input wire logic [13:0] i_conv_temp,    // conversion word
  input wire logic        o_conv_start,   // conversion start
  input wire logic [1:0]  o_conv_res,     // resolution code
  input wire logic        o_powered_down, // shutdown reached
  input wire logic        o_alert_o,      // alarm drive value
  input wire logic        o_alert_oe      // alarm pull enable
);
  // ----
  // cycles since the last conversion end or scl edge
  // ----
  logic [4:0] quiet_q;
  logic       scl_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      quiet_q <= 5'h00;
      scl_q   <= 1'b1;
    end else begin
      scl_q <= i_scl;
      if (i_conv_done || (i_scl != scl_q)) quiet_q <= 5'h00;
      else if (quiet_q != 5'h1F) quiet_q <= quiet_q + 5'h01;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_sda_open_drain: assert property (!o_sda_o) else $error("data driven high");
  a_alert_open_drain: assert property (!o_alert_o) else $error("alarm driven high");
  a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed while scl high");
  a_start_one_cycle: assert property (o_conv_start |=> !o_conv_start) else $error("start pulse too long");
  a_start_wakes: assert property (o_conv_start |=> !o_powered_down)
    else $error("shutdown shown while converting");
  a_down_after_done: assert property ($rose(o_powered_down) |-> $past(i_conv_done) || $past(i_conv_done, 2)
    || $past(i_conv_done, 3) || $past(i_conv_done, 4)) else $error("shutdown before conversion end");
  a_alarm_has_cause: assert property ($changed(o_alert_oe) |-> quiet_q != 5'h1F)
    else $error("alarm moved without cause");
  a_res_has_cause: assert property ($changed(o_conv_res) |-> quiet_q != 5'h1F)
    else $error("resolution moved without cause");
endmodule : tsra_chk

bind tsra_top tsra_chk u_tsra_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda_i(i_sda_i), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .i_conv_done(i_conv_done), .i_conv_temp(i_conv_temp), .o_conv_start(o_conv_start), .o_conv_res(o_conv_res),
  .o_powered_down(o_powered_down), .o_alert_o(o_alert_o), .o_alert_oe(o_alert_oe)
);

//--- testbench/tsra_host.sv
// serial bus master model, clock period 125 ns
`timescale 1ns/1ps

module tsra_host (
  output logic      o_scl,    // serial clock
  output logic      o_sda_oe, // high while pulling data low
  input wire logic  i_sda     // resolved data line
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // one bit: drive after the fall, sample before the next fall
  task put_bit(input logic b, output logic r);
    #5;
    o_sda_oe = !b;
    #57.5;
    o_scl = 1'b1;
    #62.5;
    r = i_sda;
    o_scl = 1'b0;
  endtask : put_bit

  // also serves as repeated start when entered with scl low
  task bus_start();
    #5;
    o_sda_oe = 1'b0;
    #57.5;
    o_scl = 1'b1;
    #200;
    o_sda_oe = 1'b1;
    #200;
    o_scl = 1'b0;
  endtask : bus_start

  task bus_stop();
    #5;
    o_sda_oe = 1'b1;
    #57.5;
    o_scl = 1'b1;
    #200;
    o_sda_oe = 1'b0;
    #200;
  endtask : bus_stop

  task put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = !r;
  endtask : put_byte

  // last byte ends with no acknowledge
  task get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(last, r);
  endtask : get_byte
endmodule : tsra_host

//--- testbench/temp_sensor_register_access_tb.sv
// self-checking bench of the temperature sensor register access block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

module temp_sensor_register_access_tb;
  localparam logic [6:0]  ADDR  = 7'h48;
  localparam logic [15:0] IDENT = 16'h5AC3; // arbitrary identification value
  logic        i_clk, i_rstn, scl, m_oe, sda, done, hold, c_start, c_down, s_oe, ack, a_oe;
  logic [13:0] temp;
  logic [1:0]  c_res;
  logic [15:0] v;
  int          busy, nstart, num_errors, cmp_count;
  assign sda = !(m_oe || s_oe);

  tsra_top #(.DEV_ADDR(ADDR), .IDENT_VALUE(IDENT)) u_tsra_top (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda_i(sda), .o_sda_o(), .o_sda_oe(s_oe),
    .i_conv_done(done), .i_conv_temp(temp), .o_conv_start(c_start), .o_conv_res(c_res),
    .o_powered_down(c_down), .o_alert_o(), .o_alert_oe(a_oe));
  tsra_host u_tsra_host (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // converter: eight cycles per conversion, stalls on its last cycle while hold
  always @(posedge i_clk) begin
    #2;
    done = i_rstn && !c_start && busy == 1 && !hold;
    if (!i_rstn) busy = 0;
    else if (c_start) begin
      busy = 8;
      nstart++;
    end else if (busy > 1 || done) begin
      busy--;
    end
  end

  function logic [15:0] exp_res(input logic [13:0] t, input logic [1:0] r);
    return {t, 2'b00} & (16'hFFFF << (3'd5 - r));
  endfunction : exp_res

  function logic exp_oe(input logic act, input logic hi, input logic off);
    return !(off ? !hi : (act ? hi : !hi));
  endfunction : exp_oe

  task wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask : wait_clk

  task wr(input logic [7:0] sel, input int nd, input logic [15:0] d, output logic sack);
    logic a;
    u_tsra_host.bus_start();
    u_tsra_host.put_byte({ADDR, 1'b0}, a);
    u_tsra_host.put_byte(sel, sack);
    if (nd > 0) u_tsra_host.put_byte(d[15:8], a);
    if (nd > 1) u_tsra_host.put_byte(d[7:0], a);
    u_tsra_host.bus_stop();
    wait_clk(1);
  endtask : wr

  task rd(input logic [7:0] sel, input logic set, input logic two, output logic [15:0] d);
    logic a;
    u_tsra_host.bus_start();
    if (set) begin
      u_tsra_host.put_byte({ADDR, 1'b0}, a);
      u_tsra_host.put_byte(sel, a);
      u_tsra_host.bus_start();
    end
    u_tsra_host.put_byte({ADDR, 1'b1}, a);
    d = 16'h0000;
    u_tsra_host.get_byte(!two, d[15:8]);
    if (two) u_tsra_host.get_byte(1'b1, d[7:0]);
    u_tsra_host.bus_stop();
    wait_clk(1);
  endtask : rd

  task conclude();
    $display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    #3000000;
    num_errors++;
    conclude();
  end

  initial begin
    i_rstn = 1'b0;
    temp = 14'h0000;
    hold = 1'b1;
    done = 1'b0;
    busy = 0;
    nstart = 0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(55));
    repeat (6) @(posedge i_clk);
    #2 i_rstn = 1'b1;
    wait_clk(4);
    rd(8'h00, 1'b0, 1'b1, v); `CHK(v, 16'h7FFC)
    rd(8'h01, 1'b1, 1'b0, v); `CHK(v[15:8], 8'h40)
    rd(8'h04, 1'b1, 1'b0, v); `CHK(v[15:8], 8'h08)
    rd(8'h07, 1'b1, 1'b1, v); `CHK(v, IDENT)
    for (int c = 0; c < 8; c++) begin
      wr(c[7:0], 0, 16'h0000, ack); `CHK(ack, (c != 5 && c != 6))
    end
    wr(8'h0C, 0, 16'h0000, ack); `CHK(ack, 1'b0)
    wr(8'h06, 2, 16'h0040, ack);
    rd(8'h00, 1'b0, 1'b1, v); `CHK(v, IDENT)
    hold = 1'b0;
    for (int r = 3; r >= 0; r--) begin
      temp = 14'($urandom) & 14'h37FF;
      wr(8'h04, 1, {1'b0, r[1:0], 13'h0000}, ack);
      wait_clk(40);
      `CHK(c_res, r[1:0])
      rd(8'h00, 1'b1, 1'b1, v); `CHK(v, exp_res(temp, r[1:0]))
    end
    rd(8'h04, 1'b1, 1'b0, v); `CHK(v[8], 1'b1)
    wr(8'h00, 2, 16'h1234, ack);
    rd(8'h00, 1'b0, 1'b1, v); `CHK(v, exp_res(temp, 2'h0))
    temp = 14'h1000;
    wr(8'h02, 2, 16'h1000, ack);
    wait_clk(40); `CHK(a_oe, exp_oe(1'b1, 1'b0, 1'b0))
    hold = 1'b1;
    wait_clk(20);
    wr(8'h01, 1, 16'h4800, ack);
    wait_clk(10); `CHK(a_oe, exp_oe(1'b0, 1'b0, 1'b0))
    rd(8'h01, 1'b0, 1'b0, v); `CHK(v[15:8], 8'h40)
    hold = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      wr(8'h01, 1, {2'b01, k[1], k[0], 12'h000}, ack);
      wait_clk(30); `CHK(a_oe, exp_oe(1'b1, k[0], k[1]))
    end
    temp = 14'h0100;
    wr(8'h03, 2, 16'h0800, ack);
    wait_clk(40); `CHK(a_oe, exp_oe(1'b0, 1'b0, 1'b0))
    hold = 1'b1;
    wr(8'h01, 1, 16'hC000, ack);
    wait_clk(20); `CHK(c_down, 1'b0)
    temp = 14'h0AAA;
    hold = 1'b0;
    wait_clk(20); `CHK(c_down, 1'b1)
    rd(8'h00, 1'b1, 1'b1, v); `CHK(v, exp_res(temp, 2'h0))
    nstart = 0;
    temp = 14'h1555;
    wr(8'h01, 1, 16'hC400, ack);
    wait_clk(40); `CHK(nstart, 1)
    rd(8'h00, 1'b1, 1'b1, v); `CHK(v, exp_res(temp, 2'h0))
    wr(8'h01, 1, 16'h4000, ack);
    wait_clk(40); `CHK(nstart > 2, 1'b1)
    conclude();
  end
endmodule : temp_sensor_register_access_tb
